/* File: inc/epw_pkg.sv */
/*
 * Shared constants and types for the enhanced PWM unit and its period timer:
 * register byte addresses, reset values, field positions, bus carriers.
 * Assumes an AXI4-Lite master with 32-bit data and a single clock domain.
 */
package epw_pkg;

	// Register byte addresses on the AXI4-Lite bus.
	localparam int unsigned ADDR_W          = 8;
	localparam logic [7:0]  ADDR_TMR_COUNT  = 8'h00;
	localparam logic [7:0]  ADDR_TMR_CTRL   = 8'h04;
	localparam logic [7:0]  ADDR_TMR_LIMIT  = 8'h08;
	localparam logic [7:0]  ADDR_DUTY_LO    = 8'h0C;
	localparam logic [7:0]  ADDR_DUTY_HI    = 8'h10;
	localparam logic [7:0]  ADDR_UNIT_CTRL  = 8'h14;
	localparam logic [7:0]  ADDR_SHDN_CTRL  = 8'h18;
	localparam logic [7:0]  ADDR_RESTART    = 8'h1C;
	localparam logic [7:0]  ADDR_IRQ_STAT   = 8'h20;
	localparam logic [7:0]  ADDR_IRQ_MASK   = 8'h24;
	localparam logic [7:0]  ADDR_PIN_DIR    = 8'h28;

	// Reset values.
	localparam logic [7:0]  RST_ZERO        = 8'h00;
	localparam logic [7:0]  RST_TMR_LIMIT   = 8'hFF;
	localparam logic [7:0]  RST_PIN_DIR     = 8'h01;

	// Field positions and masks.
	localparam int unsigned CTL_ON_BIT      = 2;
	localparam int unsigned CTL_PS_LSB      = 0;
	localparam int unsigned CTL_OPS_LSB     = 3;
	localparam logic [7:0]  CTL_IMPL_MASK   = 8'h7F;
	localparam int unsigned UNIT_MODE_LSB   = 2;
	localparam logic [1:0]  UNIT_MODE_PWM   = 2'h3;
	localparam int unsigned IRQ_PERIOD_BIT  = 1;
	localparam int unsigned IRQ_OSCF_BIT    = 7;
	localparam logic [7:0]  IRQ_IMPL_MASK   = 8'h82;
	localparam int unsigned PIN_DIR_BIT     = 0;
	localparam logic [7:0]  PIN_DIR_MASK    = 8'h01;
	// Bits kept implemented on the small-package build.
	localparam logic [7:0]  UNIT_SMALL_MASK = 8'h3F;
	localparam logic [7:0]  SHDN_SMALL_MASK = 8'hFC;
	localparam logic [7:0]  RSTR_SMALL_MASK = 8'h80;

	// Prescaler terminal counts for divide by 1, 4 and 16.
	localparam logic [3:0]  PS_END_1        = 4'h0;
	localparam logic [3:0]  PS_END_4        = 4'h3;
	localparam logic [3:0]  PS_END_16       = 4'hF;

	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_SLVERR     = 2'h2;

	// Clock source feeding the period timer, one-hot.
	typedef enum logic [2:0] {
		EPW_CK_PRIMARY = 3'b001,
		EPW_CK_ALT     = 3'b010,
		EPW_CK_INT_OSC = 3'b100
	} epw_clk_src_e;

	typedef struct packed {
		logic              awvalid;
		logic [ADDR_W-1:0] awaddr;
		logic              wvalid;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              bready;
		logic              arvalid;
		logic [ADDR_W-1:0] araddr;
		logic              rready;
	} epw_axi_req_s;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} epw_axi_rsp_s;

endpackage : epw_pkg

/* File: hdl/epw_unit.sv */
/*
 * Enhanced PWM unit with its period timer, power-mode clock gating,
 * clock-failure switchover and an AXI4-Lite register slave.
 * Assumes the power controller supplies sleep, mode and tick strobes
 * synchronous to i_mclk, and one AXI4-Lite master.
 */
`timescale 1ns/1ps

// What this block does
// - In sleep the period timer does not count; only clock source, failure flag and interrupt status change.
// - In sleep an actively driven PWM pin keeps its level until wake.
// - On wake the unit continues from the exact state held at sleep entry.
// - In primary-clock idle the unit keeps running on the primary clock.
// - In other power modes the timer advances on the selected mode clock.
// - A monitored clock failure enters internal-osc run and sets flag bit 7.
// - After clock failure the timer advances on the internal oscillator.
// - Any reset makes the pin an input and resets every unit register.
// - After reset the unit is in basic-compatible mode, no PWM active.
// - On the small package the output, shutdown-B/D and delay bits are 0.
// - Unimplemented bits, such as timer control bit 7, read as zero.
module epw_unit
	import epw_pkg::*;
#(
	parameter bit SMALL_PKG = 1'b0
) (
	input  wire logic         i_mclk,
	input  wire logic         i_rst,
	input  wire epw_axi_req_s i_axi_req,
	output epw_axi_rsp_s      o_axi_rsp,
	input  wire logic         i_sleep,
	input  wire logic         i_pm_alt,
	input  wire logic         i_alt_tick,
	input  wire logic         i_int_osc_tick,
	input  wire logic         i_fscm_en,
	input  wire logic         i_clk_fail,
	output logic              o_pwm_out,
	output logic              o_pwm_oe_n,
	output logic              o_int_run,
	output logic              o_irq
);

	// Address decode used by both the write and the read path.
	function automatic logic addr_known(input logic [ADDR_W-1:0] a);
		case (a)
			ADDR_TMR_COUNT, ADDR_TMR_CTRL, ADDR_TMR_LIMIT, ADDR_DUTY_LO,
			ADDR_DUTY_HI, ADDR_UNIT_CTRL, ADDR_SHDN_CTRL, ADDR_RESTART,
			ADDR_IRQ_STAT, ADDR_IRQ_MASK, ADDR_PIN_DIR: addr_known = 1'b1;
			default: addr_known = 1'b0;
		endcase
	endfunction : addr_known

	// Unimplemented positions on the small package are forced low.
	localparam logic [7:0] UNIT_WMASK = SMALL_PKG ? UNIT_SMALL_MASK : 8'hFF;
	localparam logic [7:0] SHDN_WMASK = SMALL_PKG ? SHDN_SMALL_MASK : 8'hFF;
	localparam logic [7:0] RSTR_WMASK = SMALL_PKG ? RSTR_SMALL_MASK : 8'hFF;

	epw_axi_rsp_s          rsp_next;
	logic                  aw_full_reg, aw_full_next;
	logic                  w_full_reg, w_full_next;
	logic [ADDR_W-1:0]     awaddr_reg, awaddr_next;
	logic [7:0]            wbyte_reg, wbyte_next;
	logic                  wlane_reg, wlane_next;
	logic                  wr_en;
	logic [ADDR_W-1:0]     wr_addr;
	logic [7:0]            wr_data;
	logic [7:0]            rd_byte;

	logic [7:0]   tmr_count_reg, tmr_count_next;
	logic [7:0]   tmr_ctrl_reg, tmr_ctrl_next;
	logic [7:0]   tmr_limit_reg, tmr_limit_next;
	logic [7:0]   duty_lo_reg, duty_lo_next;
	logic [7:0]   duty_hi_reg, duty_hi_next;
	logic [7:0]   unit_ctrl_reg, unit_ctrl_next;
	logic [7:0]   shdn_ctrl_reg, shdn_ctrl_next;
	logic [7:0]   restart_reg, restart_next;
	logic [7:0]   irq_stat_reg, irq_stat_next;
	logic [7:0]   irq_mask_reg, irq_mask_next;
	logic [7:0]   pin_dir_reg, pin_dir_next;
	logic [3:0]   pre_cnt_reg, pre_cnt_next;
	logic [3:0]   post_cnt_reg, post_cnt_next;
	logic         fail_reg, fail_next;
	epw_clk_src_e clk_src_reg, clk_src_next;
	logic         pwm_out_next, oe_n_next, int_run_next, irq_next;
	logic         tick;
	logic [3:0]   pre_end;
	logic [7:0]   events;

	// Read mux; unmapped addresses and unimplemented bits read as zero.
	always_comb begin
		case (i_axi_req.araddr)
			ADDR_TMR_COUNT: rd_byte = tmr_count_reg;
			ADDR_TMR_CTRL:  rd_byte = tmr_ctrl_reg & CTL_IMPL_MASK;
			ADDR_TMR_LIMIT: rd_byte = tmr_limit_reg;
			ADDR_DUTY_LO:   rd_byte = duty_lo_reg;
			ADDR_DUTY_HI:   rd_byte = duty_hi_reg;
			ADDR_UNIT_CTRL: rd_byte = unit_ctrl_reg;
			ADDR_SHDN_CTRL: rd_byte = shdn_ctrl_reg;
			ADDR_RESTART:   rd_byte = restart_reg;
			ADDR_IRQ_STAT:  rd_byte = irq_stat_reg;
			ADDR_IRQ_MASK:  rd_byte = irq_mask_reg;
			ADDR_PIN_DIR:   rd_byte = pin_dir_reg;
			default:        rd_byte = RST_ZERO;
		endcase
	end

	// Bus slave: address and data are taken in either order, the write
	// happens once both are held, and a single response follows.
	always_comb begin
		rsp_next     = o_axi_rsp;
		aw_full_next = aw_full_reg;
		w_full_next  = w_full_reg;
		awaddr_next  = awaddr_reg;
		wbyte_next   = wbyte_reg;
		wlane_next   = wlane_reg;
		wr_en        = 1'b0;
		wr_addr      = awaddr_reg;
		wr_data      = wbyte_reg;
		if (o_axi_rsp.awready && i_axi_req.awvalid) begin
			aw_full_next = 1'b1;
			awaddr_next  = i_axi_req.awaddr;
		end
		if (o_axi_rsp.wready && i_axi_req.wvalid) begin
			w_full_next = 1'b1;
			wbyte_next  = i_axi_req.wdata[7:0];
			wlane_next  = i_axi_req.wstrb[0];
		end
		if (o_axi_rsp.bvalid && i_axi_req.bready) begin
			rsp_next.bvalid = 1'b0;
		end
		if (aw_full_next && w_full_next && !o_axi_rsp.bvalid) begin
			// Only byte lane 0 carries register data.
			wr_en           = wlane_next && addr_known(awaddr_next);
			wr_addr         = awaddr_next;
			wr_data         = wbyte_next;
			rsp_next.bvalid = 1'b1;
			rsp_next.bresp  = addr_known(awaddr_next) ? RESP_OKAY
			                                          : RESP_SLVERR;
			aw_full_next    = 1'b0;
			w_full_next     = 1'b0;
		end
		rsp_next.awready = !aw_full_next && !rsp_next.bvalid;
		rsp_next.wready  = !w_full_next && !rsp_next.bvalid;
		if (o_axi_rsp.rvalid && i_axi_req.rready) begin
			rsp_next.rvalid = 1'b0;
		end
		if (o_axi_rsp.arready && i_axi_req.arvalid) begin
			rsp_next.rvalid = 1'b1;
			rsp_next.rdata  = {24'h000000, rd_byte};
			rsp_next.rresp  = addr_known(i_axi_req.araddr) ? RESP_OKAY
			                                               : RESP_SLVERR;
		end
		rsp_next.arready = !rsp_next.rvalid;
	end

	// Bus slave registers; all handshakes start low in reset.
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_axi_rsp   <= '0;
			aw_full_reg <= 1'b0;
			w_full_reg  <= 1'b0;
			awaddr_reg  <= '0;
			wbyte_reg   <= RST_ZERO;
			wlane_reg   <= 1'b0;
		end else begin
			o_axi_rsp   <= rsp_next;
			aw_full_reg <= aw_full_next;
			w_full_reg  <= w_full_next;
			awaddr_reg  <= awaddr_next;
			wbyte_reg   <= wbyte_next;
			wlane_reg   <= wlane_next;
		end
	end

	// Timer tick from the active clock source.
	always_comb begin
		case (clk_src_reg)
			EPW_CK_PRIMARY: tick = 1'b1;
			EPW_CK_ALT:     tick = i_alt_tick;
			EPW_CK_INT_OSC: tick = i_int_osc_tick;
			default:        tick = 1'b0;
		endcase
		case (tmr_ctrl_reg[CTL_PS_LSB +: 2])
			2'h0:    pre_end = PS_END_1;
			2'h1:    pre_end = PS_END_4;
			default: pre_end = PS_END_16;
		endcase
	end

	// Unit state: registers, period timer, PWM output, clock source, flags.
	// The clock-source and flag logic sits outside the frozen unit so a
	// failure seen during sleep is still recorded.
	always_comb begin
		tmr_count_next = tmr_count_reg;
		tmr_ctrl_next  = tmr_ctrl_reg;
		tmr_limit_next = tmr_limit_reg;
		duty_lo_next   = duty_lo_reg;
		duty_hi_next   = duty_hi_reg;
		unit_ctrl_next = unit_ctrl_reg;
		shdn_ctrl_next = shdn_ctrl_reg;
		restart_next   = restart_reg;
		irq_mask_next  = irq_mask_reg;
		pin_dir_next   = pin_dir_reg;
		pre_cnt_next   = pre_cnt_reg;
		post_cnt_next  = post_cnt_reg;
		pwm_out_next   = o_pwm_out;
		events         = RST_ZERO;
		fail_next      = fail_reg;
		if (i_fscm_en && i_clk_fail && !fail_reg) begin
			fail_next                = 1'b1;
			events[IRQ_OSCF_BIT]     = 1'b1;
		end
		if (fail_next) begin
			clk_src_next = EPW_CK_INT_OSC;
		end else if (i_pm_alt) begin
			clk_src_next = EPW_CK_ALT;
		end else begin
			clk_src_next = EPW_CK_PRIMARY;
		end
		if (!i_sleep) begin
			if (tmr_ctrl_reg[CTL_ON_BIT] && tick) begin
				pre_cnt_next = pre_cnt_reg + 4'h1;
				if (pre_cnt_reg >= pre_end) begin
					pre_cnt_next = 4'h0;
					if (tmr_count_reg == tmr_limit_reg) begin
						// Period end reloads the duty shadow.
						tmr_count_next = 8'h00;
						duty_hi_next   = duty_lo_reg;
						if (post_cnt_reg ==
						    tmr_ctrl_reg[CTL_OPS_LSB +: 4]) begin
							post_cnt_next          = 4'h0;
							events[IRQ_PERIOD_BIT] = 1'b1;
						end else begin
							post_cnt_next = post_cnt_reg + 4'h1;
						end
					end else begin
						tmr_count_next = tmr_count_reg + 8'h01;
					end
				end
			end
			if (wr_en) begin
				case (wr_addr)
					ADDR_TMR_COUNT: tmr_count_next = wr_data;
					ADDR_TMR_CTRL:  tmr_ctrl_next = wr_data & CTL_IMPL_MASK;
					ADDR_TMR_LIMIT: tmr_limit_next = wr_data;
					ADDR_DUTY_LO:   duty_lo_next = wr_data;
					ADDR_DUTY_HI:   duty_hi_next = wr_data;
					ADDR_UNIT_CTRL: unit_ctrl_next = wr_data & UNIT_WMASK;
					ADDR_SHDN_CTRL: shdn_ctrl_next = wr_data & SHDN_WMASK;
					ADDR_RESTART:   restart_next = wr_data & RSTR_WMASK;
					ADDR_IRQ_MASK:  irq_mask_next = wr_data & IRQ_IMPL_MASK;
					ADDR_PIN_DIR:   pin_dir_next = wr_data & PIN_DIR_MASK;
					default:        pin_dir_next = pin_dir_reg;
				endcase
			end
			pwm_out_next = (unit_ctrl_reg[UNIT_MODE_LSB +: 2] ==
			                UNIT_MODE_PWM) && (tmr_count_reg < duty_hi_reg);
		end
		// Write-one-to-clear, but a new event in the same cycle wins.
		irq_stat_next = irq_stat_reg | events;
		if (wr_en && wr_addr == ADDR_IRQ_STAT) begin
			irq_stat_next = (irq_stat_reg & ~wr_data) | events;
		end
		oe_n_next    = pin_dir_next[PIN_DIR_BIT];
		int_run_next = (clk_src_next == EPW_CK_INT_OSC);
		irq_next     = |(irq_stat_next & irq_mask_next);
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			tmr_count_reg <= RST_ZERO;
			tmr_ctrl_reg  <= RST_ZERO;
			tmr_limit_reg <= RST_TMR_LIMIT;
			duty_lo_reg   <= RST_ZERO;
			duty_hi_reg   <= RST_ZERO;
			unit_ctrl_reg <= RST_ZERO;
			shdn_ctrl_reg <= RST_ZERO;
			restart_reg   <= RST_ZERO;
			irq_stat_reg  <= RST_ZERO;
			irq_mask_reg  <= RST_ZERO;
			pin_dir_reg   <= RST_PIN_DIR;
			pre_cnt_reg   <= 4'h0;
			post_cnt_reg  <= 4'h0;
			fail_reg      <= 1'b0;
			clk_src_reg   <= EPW_CK_PRIMARY;
			o_pwm_out     <= 1'b0;
			o_pwm_oe_n    <= 1'b1;
			o_int_run     <= 1'b0;
			o_irq         <= 1'b0;
		end else begin
			tmr_count_reg <= tmr_count_next;
			tmr_ctrl_reg  <= tmr_ctrl_next;
			tmr_limit_reg <= tmr_limit_next;
			duty_lo_reg   <= duty_lo_next;
			duty_hi_reg   <= duty_hi_next;
			unit_ctrl_reg <= unit_ctrl_next;
			shdn_ctrl_reg <= shdn_ctrl_next;
			restart_reg   <= restart_next;
			irq_stat_reg  <= irq_stat_next;
			irq_mask_reg  <= irq_mask_next;
			pin_dir_reg   <= pin_dir_next;
			pre_cnt_reg   <= pre_cnt_next;
			post_cnt_reg  <= post_cnt_next;
			fail_reg      <= fail_next;
			clk_src_reg   <= clk_src_next;
			o_pwm_out     <= pwm_out_next;
			o_pwm_oe_n    <= oe_n_next;
			o_int_run     <= int_run_next;
			o_irq         <= irq_next;
		end
	end

	// Checks on the power, clock and reset behaviour.
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_rst);

	sequence s_sleep_then_wake;
		i_sleep ##1 !i_sleep;
	endsequence

	chk_sleep_timer: assert property (
		i_sleep |=> tmr_count_reg == $past(tmr_count_reg) &&
		            pre_cnt_reg == $past(pre_cnt_reg) &&
		            duty_hi_reg == $past(duty_hi_reg))
		else $error("Timer state moved during sleep.");

	chk_sleep_pin: assert property (
		i_sleep[*2] |-> $stable(o_pwm_out) && $stable(o_pwm_oe_n))
		else $error("Pin level changed during sleep.");

	chk_wake_resume: assert property (
		s_sleep_then_wake |-> tmr_count_reg == $past(tmr_count_reg) &&
		                      post_cnt_reg == $past(post_cnt_reg))
		else $error("Unit state reinitialised on wake.");

	chk_primary_count: assert property (
		clk_src_reg == EPW_CK_PRIMARY && !i_sleep && !wr_en &&
		tmr_ctrl_reg[CTL_ON_BIT] && pre_end == PS_END_1 &&
		tmr_count_reg != tmr_limit_reg
		|=> tmr_count_reg == $past(tmr_count_reg) + 8'h01)
		else $error("Primary clock did not advance the timer.");

	chk_alt_gate: assert property (
		clk_src_reg == EPW_CK_ALT && !i_alt_tick && !wr_en
		|=> $stable(tmr_count_reg) && $stable(pre_cnt_reg))
		else $error("Timer moved without a mode clock tick.");

	chk_fail_switch: assert property (
		i_fscm_en && i_clk_fail && !fail_reg
		|=> clk_src_reg == EPW_CK_INT_OSC && irq_stat_reg[IRQ_OSCF_BIT]
		    && o_int_run)
		else $error("Clock failure not switched or flagged.");

	chk_int_osc_gate: assert property (
		clk_src_reg == EPW_CK_INT_OSC && !i_int_osc_tick && !wr_en
		|=> $stable(tmr_count_reg) && $stable(pre_cnt_reg))
		else $error("Timer moved without an internal osc tick.");

	chk_reset_pins: assert property (
		@(posedge i_mclk) disable iff (1'b0)
		i_rst |=> o_pwm_oe_n && tmr_ctrl_reg == RST_ZERO
		&& shdn_ctrl_reg == RST_ZERO && tmr_limit_reg == RST_TMR_LIMIT)
		else $error("Reset left a pin driven or a register set.");

	chk_reset_basic: assert property (
		@(posedge i_mclk) disable iff (1'b0)
		i_rst |=> !o_pwm_out && unit_ctrl_reg == RST_ZERO
		&& restart_reg == RST_ZERO)
		else $error("Enhanced feature active after reset.");

	chk_small_zero: assert property (
		SMALL_PKG |-> (unit_ctrl_reg & ~UNIT_SMALL_MASK) == RST_ZERO &&
		(shdn_ctrl_reg & ~SHDN_SMALL_MASK) == RST_ZERO &&
		(restart_reg & ~RSTR_SMALL_MASK) == RST_ZERO)
		else $error("Unimplemented small package bit is set.");

	chk_ctrl_top_zero: assert property (
		o_axi_rsp.arready && i_axi_req.arvalid &&
		i_axi_req.araddr == ADDR_TMR_CTRL
		|=> o_axi_rsp.rvalid && o_axi_rsp.rdata[31:7] == '0)
		else $error("Timer control top bit read as one.");

	chk_irq_level: assert property (
		o_irq == |(irq_stat_reg & irq_mask_reg))
		else $error("Interrupt output does not follow status.");

endmodule : epw_unit

/* File: verif/epw_pm_model.sv */
/*
 * Behavioural model of the clock and power controller that feeds the PWM
 * unit: sleep, power-mode select, failure monitor and the two slow clocks.
 * Assumes the bench requests each condition as a level on i_mclk edges.
 */
`timescale 1ns/1ps

module epw_pm_model
	import epw_pkg::*;
#(
	parameter int unsigned ALT_DIV = 3,
	parameter int unsigned OSC_DIV = 5
) (
	input  wire logic i_mclk,
	input  wire logic i_rst,
	input  wire logic i_sleep_req,
	input  wire logic i_alt_req,
	input  wire logic i_fail_req,
	input  wire logic i_fscm_req,
	input  wire logic i_tick_en,
	output logic      o_sleep,
	output logic      o_pm_alt,
	output logic      o_alt_tick,
	output logic      o_int_osc_tick,
	output logic      o_fscm_en,
	output logic      o_clk_fail
);

	logic [3:0] alt_reg, alt_next;
	logic [3:0] osc_reg, osc_next;

	// Dividers are held at zero while ticks are disabled, so every pulse is counted.
	always_comb begin
		alt_next = (alt_reg == 4'(ALT_DIV - 1)) ? 4'h0 : alt_reg + 4'h1;
		osc_next = (osc_reg == 4'(OSC_DIV - 1)) ? 4'h0 : osc_reg + 4'h1;
		if (!i_tick_en) begin
			alt_next = 4'h0;
			osc_next = 4'h0;
		end
	end

	// All strobes leave flops, like a real controller in this clock domain.
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			alt_reg       <= 4'h0;
			osc_reg       <= 4'h0;
			o_alt_tick    <= 1'b0;
			o_int_osc_tick <= 1'b0;
			o_sleep       <= 1'b0;
			o_pm_alt      <= 1'b0;
			o_fscm_en     <= 1'b0;
			o_clk_fail    <= 1'b0;
		end else begin
			alt_reg       <= alt_next;
			osc_reg       <= osc_next;
			o_alt_tick    <= i_tick_en && (alt_reg == 4'(ALT_DIV - 1));
			o_int_osc_tick <= i_tick_en && (osc_reg == 4'(OSC_DIV - 1));
			o_sleep       <= i_sleep_req;
			o_pm_alt      <= i_alt_req;
			o_fscm_en     <= i_fscm_req;
			o_clk_fail    <= i_fail_req;
		end
	end

endmodule : epw_pm_model

/* File: verif/enhanced_pwm_power_reset_behaviour_tb.sv */
/*
 * Self-checking bench for the PWM unit: register reset values, sleep
 * freeze, mode clocks, clock failure, interrupts and small-package bits.
 * Assumes the unit and the power controller model share one 25 MHz clock.
 */
`timescale 1ns/1ps

module enhanced_pwm_power_reset_behaviour_tb
	import epw_pkg::*;
;
	localparam logic [7:0] RA [3] = '{ADDR_UNIT_CTRL, ADDR_SHDN_CTRL,
		ADDR_RESTART};
	localparam logic [7:0] RM [3] = '{8'h3F, 8'hFC, 8'h80};

	logic         clk, rst, slp, alt, fail, fscm, tick_en;
	logic         p_slp, p_alt, a_tk, o_tk, p_fscm, p_fail;
	logic         pwm, oe_n, int_run, irq;
	epw_axi_req_s req;
	epw_axi_rsp_s rsp, rsp2;
	logic [31:0]  seed, rd, rd2;
	logic [1:0]   rr, br;
	logic [7:0]   c0, v;
	logic [1:0]   lvl;
	int           num_errors, checks, n;

	epw_pm_model pm (.i_mclk(clk), .i_rst(rst), .i_sleep_req(slp),
		.i_alt_req(alt), .i_fail_req(fail), .i_fscm_req(fscm),
		.i_tick_en(tick_en), .o_sleep(p_slp), .o_pm_alt(p_alt),
		.o_alt_tick(a_tk), .o_int_osc_tick(o_tk), .o_fscm_en(p_fscm),
		.o_clk_fail(p_fail));

	epw_unit #(.SMALL_PKG(1'b0)) uut (.i_mclk(clk), .i_rst(rst),
		.i_axi_req(req), .o_axi_rsp(rsp), .i_sleep(p_slp), .i_pm_alt(p_alt),
		.i_alt_tick(a_tk), .i_int_osc_tick(o_tk), .i_fscm_en(p_fscm),
		.i_clk_fail(p_fail), .o_pwm_out(pwm), .o_pwm_oe_n(oe_n),
		.o_int_run(int_run), .o_irq(irq));

	// The small-package build shares the bus so read data line up.
	epw_unit #(.SMALL_PKG(1'b1)) uut_small (.i_mclk(clk), .i_rst(rst),
		.i_axi_req(req), .o_axi_rsp(rsp2), .i_sleep(p_slp),
		.i_pm_alt(p_alt), .i_alt_tick(a_tk), .i_int_osc_tick(o_tk),
		.i_fscm_en(p_fscm), .i_clk_fail(p_fail), .o_pwm_out(),
		.o_pwm_oe_n(), .o_int_run(), .o_irq());

	// Free-running 25 MHz clock.
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs

	// Limit and pin direction are the only registers not cleared.
	function automatic logic [7:0] exp_rst(input logic [7:0] a);
		case (a)
			8'h08:   return 8'hFF;
			8'h28:   return 8'h01;
			default: return 8'h00;
		endcase
	endfunction : exp_rst

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic stop_test();
		if (num_errors == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : stop_test

	// Each channel is released at the edge that takes it.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		req.awvalid <= 1'b1;
		req.awaddr  <= a;
		req.wvalid  <= 1'b1;
		req.wdata   <= {24'h000000, d};
		req.wstrb   <= 4'hF;
		req.bready  <= 1'b1;
		forever begin
			@(posedge clk);
			if (rsp.awready && req.awvalid) req.awvalid <= 1'b0;
			if (rsp.wready && req.wvalid) req.wvalid <= 1'b0;
			if (rsp.bvalid) begin
				br = rsp.bresp;
				req.bready <= 1'b0;
				break;
			end
		end
	endtask : wr

	task automatic rd_reg(input logic [7:0] a);
		@(posedge clk);
		req.arvalid <= 1'b1;
		req.araddr  <= a;
		req.rready  <= 1'b1;
		forever begin
			@(posedge clk);
			if (rsp.arready && req.arvalid) req.arvalid <= 1'b0;
			if (rsp.rvalid) begin
				rd = rsp.rdata;
				rd2 = rsp2.rdata;
				rr = rsp.rresp;
				req.rready <= 1'b0;
				break;
			end
		end
	endtask : rd_reg

	// Counts the pulses of one slow clock while the model emits them.
	task automatic run_ticks(input logic osc, output int cnt);
		cnt = 0;
		@(posedge clk);
		tick_en <= 1'b1;
		repeat (40) begin
			@(posedge clk);
			cnt = cnt + int'(osc ? o_tk : a_tk);
		end
		tick_en <= 1'b0;
		repeat (6) begin
			@(posedge clk);
			cnt = cnt + int'(osc ? o_tk : a_tk);
		end
	endtask : run_ticks

	// A hang is cut short well after the sequence should have ended.
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		stop_test();
	end

	// Main sequence.
	initial begin
		seed = 32'h0000000D;
		num_errors = 0;
		checks = 0;
		{rst, slp, alt, fail, fscm, tick_en} = 6'h20;
		req = '0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		check({oe_n, pwm, int_run, irq}, 32'h8);
		for (int a = 0; a < 44; a += 4) begin
			rd_reg(8'(a));
			check(rd, {24'h0, exp_rst(8'(a))});
			check(rd2, {24'h0, exp_rst(8'(a))});
		end
		rd_reg(8'h2C);
		check({rr, rd[29:0]}, {RESP_SLVERR, 30'h0});
		wr(ADDR_TMR_CTRL, 8'hFF);
		check(br, RESP_OKAY);
		wr(8'h2C, 8'h5A);
		check(br, RESP_SLVERR);
		rd_reg(ADDR_TMR_CTRL);
		check(rd, 32'h7F);
		for (int i = 0; i < 6; i++) begin
			v = 8'(xs());
			wr(RA[i % 3], v);
			rd_reg(RA[i % 3]);
			check(rd2, {24'h0, v & RM[i % 3]});
		end
		wr(ADDR_TMR_CTRL, 8'h04);
		wr(ADDR_IRQ_MASK, 8'h02);
		repeat (300) @(posedge clk);
		#1;
		check(irq, 32'h1);
		@(posedge clk);
		alt <= 1'b1;
		repeat (3) @(posedge clk);
		wr(ADDR_IRQ_STAT, 8'h02);
		rd_reg(ADDR_IRQ_STAT);
		check(rd & 32'h2, 32'h0);
		wr(ADDR_DUTY_LO, 8'h80);
		wr(ADDR_UNIT_CTRL, 8'h0C);
		wr(ADDR_PIN_DIR, 8'h00);
		wr(ADDR_TMR_COUNT, 8'h10);
		wr(ADDR_DUTY_HI, 8'hF0);
		repeat (2) @(posedge clk);
		#1;
		check({irq, oe_n, pwm}, 32'h1);
		rd_reg(ADDR_TMR_COUNT);
		c0 = rd[7:0];
		run_ticks(1'b0, n);
		rd_reg(ADDR_TMR_COUNT);
		check(rd, {24'h0, c0 + 8'(n)});
		c0 = rd[7:0];
		slp <= 1'b1;
		repeat (3) @(posedge clk);
		// The pin is driven high: count stays well below duty.
		lvl = 2'b01;
		tick_en <= 1'b1;
		repeat (30) begin
			@(posedge clk);
			#1;
			check({oe_n, pwm}, {30'h0, lvl});
		end
		@(posedge clk);
		tick_en <= 1'b0;
		wr(ADDR_DUTY_LO, 8'h11);
		rd_reg(ADDR_TMR_COUNT);
		check(rd, {24'h0, c0});
		slp <= 1'b0;
		repeat (3) @(posedge clk);
		rd_reg(ADDR_DUTY_LO);
		check(rd, 32'h80);
		run_ticks(1'b0, n);
		rd_reg(ADDR_TMR_COUNT);
		check(rd, {24'h0, c0 + 8'(n)});
		fscm <= 1'b1;
		fail <= 1'b1;
		repeat (4) @(posedge clk);
		#1;
		check(int_run, 32'h1);
		rd_reg(ADDR_IRQ_STAT);
		check(rd & 32'h80, 32'h80);
		wr(ADDR_IRQ_MASK, 8'h80);
		rd_reg(ADDR_TMR_COUNT);
		c0 = rd[7:0];
		check(irq, 32'h1);
		run_ticks(1'b1, n);
		rd_reg(ADDR_TMR_COUNT);
		check(rd, {24'h0, c0 + 8'(n)});
		{fail, fscm, rst} <= 3'h1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		check({oe_n, pwm, int_run, irq}, 32'h8);
		rd_reg(ADDR_PIN_DIR);
		check(rd, 32'h01);
		rd_reg(ADDR_UNIT_CTRL);
		check(rd, 32'h00);
		stop_test();
	end

endmodule : enhanced_pwm_power_reset_behaviour_tb
